// ===== rtl/adcotr_top.sv
// Purpose: Sleep/sensor control, output override, data mode and temperature readout
// Assumes: Serial port pins synchronous to clk; frame is R/W, 7 address, 8 data, MSB first
// Notes:   Data bits taken on sclk rising edge, read data changes after falling edge
`timescale 1ns/10ps
`default_nettype none
module adcotr_top
  import adcotr_pkg::*;
#(
  parameter int WIDTH = 12
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Serial register port
  input  wire logic             sclk,
  input  wire logic             sen_n,
  input  wire logic             sdio_in,
  output logic                  sdio_out,
  output logic                  sdio_oe,
  // Converter core
  input  wire logic [WIDTH-1:0] sample_data,
  input  wire logic [7:0]       sensor_code,
  output logic                  sleep_en,
  output logic                  temp_sensor_en,
  // Output bus
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_clk
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0]    sleep_sensor_reg;
  logic [7:0]    out_ctrl_reg;
  logic [7:0]    temp_reg;
  logic          sclk_q;
  logic [4:0]    bit_cnt;
  logic [15:0]   shift_in;
  logic [7:0]    shift_out;
  logic          is_read;
  adcotr_state_e state;
  logic [WIDTH-1:0] prbs_word;
  logic [WIDTH-1:0] toggle_word;
  logic [WIDTH-1:0] next_data;
  logic          clk_phase;

  wire sclk_rise = sclk & ~sclk_q;
  wire sclk_fall = ~sclk & sclk_q;
  wire [15:0] next_shift = {shift_in[14:0], sdio_in};

  function automatic logic [7:0] read_mux(input logic [6:0] addr,
                                          input logic [7:0] ss,
                                          input logic [7:0] oc,
                                          input logic [7:0] tr);
    case (addr)
      ADDR_SLEEP_SENSOR: read_mux = ss;
      ADDR_OUT_CTRL:     read_mux = oc;
      ADDR_TEMP:         read_mux = tr;
      default:           read_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk;
  end

  // ----------------------------------------
  // Serial frame sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state    <= ADCOTR_IDLE;
      bit_cnt  <= 5'h00;
      shift_in <= 16'h0000;
      is_read  <= 1'b0;
    end
    else if (sen_n)
    begin
      // Deselect aborts any partial frame
      state   <= ADCOTR_IDLE;
      bit_cnt <= 5'h00;
    end
    else
    begin
      case (state)
        ADCOTR_IDLE:
        begin
          bit_cnt <= 5'h00;
          state   <= ADCOTR_SHIFT;
        end
        ADCOTR_SHIFT:
        begin
          if (sclk_rise)
          begin
            shift_in <= next_shift;
            bit_cnt  <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h00)
              is_read <= sdio_in;
            if (bit_cnt + 5'h01 == FRAME_DONE)
              state <= ADCOTR_END;
          end
        end
        ADCOTR_END:
          state <= ADCOTR_END;
        default:
          state <= ADCOTR_IDLE;
      endcase
    end
  end

  wire addr_taken = (state == ADCOTR_SHIFT) && sclk_rise && (bit_cnt + 5'h01 == ADDR_DONE);
  wire write_done = (state == ADCOTR_SHIFT) && sclk_rise && (bit_cnt + 5'h01 == FRAME_DONE) && !is_read;
  // Last data bit is still in flight, so the address is read from the next word
  wire [6:0] wr_addr = next_shift[14:8];

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_out <= 8'h00;
      sdio_out  <= 1'b0;
      sdio_oe   <= 1'b0;
    end
    else if (sen_n)
    begin
      sdio_oe <= 1'b0;
      sdio_out <= 1'b0;
    end
    else if (addr_taken && is_read)
      shift_out <= read_mux(next_shift[6:0], sleep_sensor_reg, out_ctrl_reg, temp_reg);
    else if (sclk_fall && is_read && state == ADCOTR_SHIFT && bit_cnt >= ADDR_DONE)
    begin
      sdio_out  <= shift_out[7];
      sdio_oe   <= 1'b1;
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  // Reserved bit is stored as written; host keeps it at one
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sleep_sensor_reg <= RST_SLEEP_SENSOR;
    else if (write_done && wr_addr == ADDR_SLEEP_SENSOR)
      sleep_sensor_reg <= next_shift[7:0];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      out_ctrl_reg <= RST_OUT_CTRL;
    else if (write_done && wr_addr == ADDR_OUT_CTRL)
      out_ctrl_reg <= next_shift[7:0];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sleep_en       <= 1'b0;
      temp_sensor_en <= 1'b0;
    end
    else
    begin
      sleep_en       <= sleep_sensor_reg[BIT_SLEEP];
      temp_sensor_en <= sleep_sensor_reg[BIT_TEMP_EN];
    end
  end

  // Sensor value has no reset; it follows the sensor while enabled
  always_ff @(posedge clk)
  begin
    if (temp_sensor_en)
      temp_reg <= sensor_code;
  end

  // ----------------------------------------
  // Output bus
  // ----------------------------------------
  adcotr_pattern #(
    .WIDTH (WIDTH)
  ) u_pattern (
    .clk         (clk),
    .resetn      (resetn),
    .prbs_word   (prbs_word),
    .toggle_word (toggle_word)
  );

  wire [1:0] force_sel = out_ctrl_reg[FORCE_LSB +: 2];
  wire [1:0] mode_sel  = out_ctrl_reg[MODE_LSB +: 2];

  always_comb
  begin
    case (mode_sel)
      MODE_NORMAL: next_data = sample_data;
      MODE_SCRAM:  next_data = {sample_data[WIDTH-1:1] ^ {(WIDTH-1){sample_data[0]}}, sample_data[0]};
      MODE_PRBS:   next_data = prbs_word;
      MODE_TOGGLE: next_data = toggle_word;
      default:     next_data = sample_data;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      clk_phase <= 1'b0;
    else
      clk_phase <= ~clk_phase;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_data <= '0;
      out_clk  <= 1'b0;
    end
    else if (force_sel == FORCE_ZERO)
    begin
      out_data <= '0;
      out_clk  <= 1'b0;
    end
    else if (force_sel == FORCE_ONE)
    begin
      out_data <= '1;
      out_clk  <= 1'b1;
    end
    else
    begin
      out_data <= next_data;
      out_clk  <= clk_phase;
    end
  end
endmodule
`default_nettype wire

// ===== inc/adcotr_pkg.sv
// Purpose: Constants for the converter control and status register block
// Assumes: Serial register port sampled in the clk domain
// Notes:   Register map, field layout, reset values and pattern codes
// Notes on behaviour
// - Bit six zero keeps converter active; one puts it in sleep.
// - Bit seven enables temperature sensor regardless of the sleep bit.
// - Override codes 00 and 01 pass the mode-selected data (samples or test pattern) to outputs.
// - Override code 10 drives all data and clock outputs to zero.
// - Override code 11 drives all data and clock outputs to one.
// - Read-only temperature register returns eight sensor bits, no fixed reset.
package adcotr_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [6:0] ADDR_SLEEP_SENSOR = 7'h05;
  localparam logic [6:0] ADDR_OUT_CTRL     = 7'h06;
  localparam logic [6:0] ADDR_TEMP         = 7'h08;

  localparam logic [7:0] RST_SLEEP_SENSOR  = 8'h20;
  localparam logic [7:0] RST_OUT_CTRL      = 8'h04;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int BIT_TEMP_EN   = 7;
  localparam int BIT_SLEEP     = 6;
  localparam int BIT_RSVD_ONE  = 5;
  localparam int FORCE_LSB     = 0;
  localparam int MODE_LSB      = 6;

  localparam logic [1:0] FORCE_ZERO = 2'h2;
  localparam logic [1:0] FORCE_ONE  = 2'h3;

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SCRAM  = 2'h1;
  localparam logic [1:0] MODE_PRBS   = 2'h2;
  localparam logic [1:0] MODE_TOGGLE = 2'h3;

  // ----------------------------------------
  // Serial frame, PRBS seed and temperature offset
  // ----------------------------------------
  localparam int              FRAME_BITS = 16;
  localparam logic [4:0]      ADDR_DONE  = 5'h08;
  localparam logic [4:0]      FRAME_DONE = 5'h10;
  localparam logic [6:0]      PRBS_SEED  = 7'h7F;
  localparam int              TEMP_OFFSET_C = 78;

  typedef enum logic [2:0] {
    ADCOTR_IDLE  = 3'b001,
    ADCOTR_SHIFT = 3'b010,
    ADCOTR_END   = 3'b100
  } adcotr_state_e;
endpackage

// ===== rtl/adcotr_pattern.sv
// Purpose: Test pattern source for the output bus
// Assumes: Advances once per clk cycle
// Notes:   PRBS7 with taps 7 and 6, plus an all-ones/all-zeros toggle
`timescale 1ns/10ps
`default_nettype none
module adcotr_pattern
  import adcotr_pkg::*;
#(
  parameter int WIDTH = 12
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Patterns
  output logic [WIDTH-1:0]      prbs_word,
  output logic [WIDTH-1:0]      toggle_word
);
  logic [6:0] lfsr;
  logic       phase;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lfsr <= PRBS_SEED;
    else
      lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      phase <= 1'b0;
    else
      phase <= ~phase;
  end

  // Each output bit carries the sequence delayed by its index modulo 7
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      assign prbs_word[g] = lfsr[g % 7];
    end
  endgenerate

  assign toggle_word = {WIDTH{~phase}};
endmodule
`default_nettype wire

// ===== dv/adcotr_checker.sv
// Purpose: Port assertions for adcotr_top
// Assumes: Frames are decoded again from the serial pins
// Notes:   Each check except read_drive_a starts at the end of a write frame
`timescale 1ns/10ps
`default_nettype none
module adcotr_checker
  import adcotr_pkg::*;
#(
  parameter int WIDTH = 12
)(
  // Clock and reset
  input wire logic             clk,
  input wire logic             resetn,
  // Serial port
  input wire logic             sclk,
  input wire logic             sen_n,
  input wire logic             sdio_in,
  input wire logic             sdio_out,
  input wire logic             sdio_oe,
  // Core and output bus
  input wire logic [WIDTH-1:0] sample_data,
  input wire logic [7:0]       sensor_code,
  input wire logic             sleep_en,
  input wire logic             temp_sensor_en,
  input wire logic [WIDTH-1:0] out_data,
  input wire logic             out_clk
);
  logic [4:0]  n;
  logic [15:0] sh;
  logic        sp;
  logic        wd;
  assign wd = (n == FRAME_DONE) && !sh[15];
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      n  <= 5'h00;
      sh <= 16'h0000;
      sp <= 1'b0;
    end
    else
    begin
      sp <= sclk;
      if (sen_n)
        n <= 5'h00;
      else if (sclk && !sp && n != FRAME_DONE)
      begin
        n  <= n + 5'h01;
        sh <= {sh[14:0], sdio_in};
      end
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sleep_bit_a: assert property ($rose(wd) && sh[14:8] == ADDR_SLEEP_SENSOR |=> ##1 sleep_en == sh[6])
    else $error("sleep_en differs from written bit");
  sensor_bit_a: assert property ($rose(wd) && sh[14:8] == ADDR_SLEEP_SENSOR |=> ##1 temp_sensor_en == sh[7])
    else $error("temp_sensor_en differs from written bit");
  normal_out_a: assert property ($rose(wd) && sh[14:8] == ADDR_OUT_CTRL && sh[7:1] == 7'h00
    |=> out_data == $past(sample_data))
    else $error("out_data not sample data");
  force_low_a: assert property ($rose(wd) && sh[14:8] == ADDR_OUT_CTRL && sh[1:0] == FORCE_ZERO
    |=> (out_data == '0 && !out_clk) [*3])
    else $error("outputs not forced low");
  force_high_a: assert property ($rose(wd) && sh[14:8] == ADDR_OUT_CTRL && sh[1:0] == FORCE_ONE
    |=> (out_data == '1 && out_clk) [*3])
    else $error("outputs not forced high");
  toggle_pat_a: assert property ($rose(wd) && sh[14:8] == ADDR_OUT_CTRL && sh[7:1] == 7'h60
    |=> ##1 out_data == ~$past(out_data))
    else $error("toggle pattern does not invert");
  read_drive_a: assert property (sdio_oe |-> !$past(sen_n))
    else $error("sdio driven outside a frame");
  cover property ($rose(wd) && sh[14:8] == ADDR_OUT_CTRL);
  cover property ($rose(sleep_en));
  cover property ($rose(sdio_oe));
endmodule
bind adcotr_top adcotr_checker #(.WIDTH(WIDTH)) u_adcotr_checker (.clk(clk), .resetn(resetn), .sclk(sclk),
  .sen_n(sen_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sample_data(sample_data),
  .sensor_code(sensor_code), .sleep_en(sleep_en), .temp_sensor_en(temp_sensor_en), .out_data(out_data),
  .out_clk(out_clk));
`default_nettype wire

// ===== dv/adcotr_host.sv
// Purpose: Host model on the serial register port
// Assumes: sclk idles low between frames
// Notes:   Low phase is 3 clk so registered read data has settled
`timescale 1ns/10ps
`default_nettype none
module adcotr_host
  import adcotr_pkg::*;
(
  // Clock and wire
  input  wire logic clk,
  input  wire logic sdio,
  // Serial port
  output logic      sclk,
  output logic      sen_n,
  output logic      sdio_h
);
  initial
  begin
    sclk   = 1'b0;
    sen_n  = 1'b1;
    sdio_h = 1'b0;
  end
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {rw, a, d};
    if (!rw && a == ADDR_SLEEP_SENSOR)
      f[BIT_RSVD_ONE] = 1'b1;
    q = 8'h00;
    @(posedge clk) sen_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge clk) sclk <= 1'b0;
      sdio_h <= f[i];
      repeat (3) @(posedge clk);
      sclk <= 1'b1;
      q = {q[6:0], sdio};
      @(posedge clk);
    end
    @(posedge clk) sen_n <= 1'b1;
    sclk <= 1'b0;
    sdio_h <= ~sdio_h;
    repeat (2) @(posedge clk);
  endtask
  function automatic int celsius(input logic [7:0] t);
    return int'(t) - TEMP_OFFSET_C;
  endfunction
endmodule
`default_nettype wire

// ===== dv/test_adc_output_test_and_temp_regs.sv
// Purpose: Self-checking bench for adcotr_top
// Assumes: Host model issues every frame
// Notes:   Outputs are read 1 ns after an edge
`timescale 1ns/10ps
`default_nettype none
module test_adc_output_test_and_temp_regs
  import adcotr_pkg::*;
;
  logic clk = 1'b0, resetn, sclk, sen_n, sdio_h, sdio, sdio_out, sdio_oe;
  logic sleep_en, temp_sensor_en, out_clk;
  logic [11:0] sample_data, out_data, a;
  logic [7:0]  sensor_code, q;
  int          miscompares = 0, n_tests = 0, cyc = 0;
  assign sdio = sdio_oe ? sdio_out : sdio_h;
  adcotr_host u_adcotr_host (.clk(clk), .sdio(sdio), .sclk(sclk), .sen_n(sen_n), .sdio_h(sdio_h));
  adcotr_top u_adcotr_top (.clk(clk), .resetn(resetn), .sclk(sclk), .sen_n(sen_n), .sdio_in(sdio),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sample_data(sample_data), .sensor_code(sensor_code),
    .sleep_en(sleep_en), .temp_sensor_en(temp_sensor_en), .out_data(out_data), .out_clk(out_clk));
  always #4 clk = ~clk;
  // Whole run needs about 1500 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    u_adcotr_host.xfer(1'b0, ad, d, q);
    #1;
  endtask
  task automatic rd(input logic [6:0] ad);
    u_adcotr_host.xfer(1'b1, ad, 8'h00, q);
    #1;
  endtask
  task automatic t_regs();
    rd(ADDR_SLEEP_SENSOR);
    chk("reg05", 16'h0020, {8'h00, q});
    rd(ADDR_OUT_CTRL);
    chk("reg06", 16'h0004, {8'h00, q});
    rd(7'h10);
    chk("unmapped", 16'h0000, {8'h00, q});
    chk("normal", {4'h0, sample_data}, {4'h0, out_data});
    $display("regs done");
  endtask
  task automatic t_force();
    for (int c = 2; c < 4; c++)
    begin
      wr(ADDR_OUT_CTRL, 8'(c));
      chk("forced", {3'h0, {13{c[0]}}}, {3'h0, out_clk, out_data});
    end
    wr(ADDR_OUT_CTRL, 8'h01);
    chk("pass", {4'h0, sample_data}, {4'h0, out_data});
    a[0] = out_clk;
    @(posedge clk) #1;
    chk("out_clk_run", {15'h0000, ~a[0]}, {15'h0000, out_clk});
    $display("force done");
  endtask
  task automatic t_modes();
    wr(ADDR_OUT_CTRL, 8'h40);
    chk("scram", {4'h0, sample_data ^ {{11{sample_data[0]}}, 1'b0}}, {4'h0, out_data});
    @(posedge clk) sample_data <= 12'h3C6;
    repeat (2) @(posedge clk);
    #1;
    chk("scram0", 16'h03C6, {4'h0, out_data});
    wr(ADDR_OUT_CTRL, 8'hC0);
    a = out_data;
    chk("toggle_lvl", {4'h0, {12{a[0]}}}, {4'h0, a});
    @(posedge clk) #1;
    chk("toggle", 16'h0FFF, {4'h0, a ^ out_data});
    wr(ADDR_OUT_CTRL, 8'h80);
    a = out_data;
    chk("prbs_live", 16'h0001, {15'h0000, |a[6:0]});
    @(posedge clk) #1;
    chk("prbs_step", {9'h000, a[5:0], a[6] ^ a[5]}, {9'h000, out_data[6:0]});
    chk("prbs", {11'h000, out_data[11:7]}, {11'h000, out_data[4:0]});
    $display("modes done");
  endtask
  task automatic t_temp();
    sensor_code <= 8'h73;
    wr(ADDR_SLEEP_SENSOR, 8'hC0);
    chk("sleep", 16'h0003, {14'h0000, sleep_en, temp_sensor_en});
    rd(ADDR_SLEEP_SENSOR);
    chk("reg05_rsvd", 16'h00E0, {8'h00, q});
    rd(ADDR_TEMP);
    chk("temp", 16'h0073, {8'h00, q});
    chk("celsius", 16'h0025, 16'(u_adcotr_host.celsius(q)));
    wr(ADDR_TEMP, 8'h00);
    rd(ADDR_TEMP);
    chk("temp_ro", 16'h0073, {8'h00, q});
    wr(ADDR_SLEEP_SENSOR, 8'h40);
    chk("sleep_only", 16'h0002, {14'h0000, sleep_en, temp_sensor_en});
    sensor_code <= 8'h10;
    rd(ADDR_TEMP);
    chk("temp_hold", 16'h0073, {8'h00, q});
    wr(ADDR_SLEEP_SENSOR, 8'h00);
    chk("awake", 16'h0000, {14'h0000, sleep_en, temp_sensor_en});
    $display("temp done");
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    resetn = 1'b0;
    sample_data = 12'hA5B;
    sensor_code = 8'h00;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_force();
    t_modes();
    t_temp();
    stop_test();
  end
endmodule
`default_nettype wire
